// >>> cdtp_core.sv
// Data transfer path of the 8-bit core with its APB register port
//
// Chosen here: the APB register port and the address map.
`include "cdtp_map.svh"
`default_nettype none
module cdtp_core #(
    parameter int MEM_DEPTH = 64,
    parameter int IO_DEPTH  = 32
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    // APB answer
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // IO register 0 driven to the port
    output logic      [7:0]  io_port_lines
);

    localparam int MEM_AW = $clog2(MEM_DEPTH);
    localparam int IO_AW  = $clog2(IO_DEPTH);

    typedef struct packed {
        cdtp_pkg::cdtp_state_e            st;
        logic [7:0]                       acc;
        cdtp_pkg::cdtp_flags_s            flags;
        logic                             err;
        logic                             cnt_en;
        logic [15:0]                      count;
        logic [7:0]                       ptr;
        logic [MEM_DEPTH-1:0][7:0]        mem;
        logic [IO_DEPTH-1:0][7:0]         io;
        logic [31:0]                      rdata;
        logic                             ready;
        logic                             slverr;
    } cdtp_regs_s;

    cdtp_regs_s r_q;
    cdtp_regs_s r_d;

    function automatic cdtp_pkg::cdtp_alu_s alu(input logic [7:0] a, input logic [7:0] b,
                                                input logic sub);
        cdtp_pkg::cdtp_alu_s o;
        logic [8:0] s;
        logic [4:0] n;
        if (sub) begin
            s = {1'b0, a} - {1'b0, b};
            n = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        end else begin
            s = {1'b0, a} + {1'b0, b};
            n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        end
        o.res = s[7:0];
        o.flags.z = (s[7:0] == 8'h00);
        o.flags.c = s[8];
        o.flags.half_nibble_flag = n[4];
        o.flags.signed_range_flag = (a[7] == (b[7] ^ sub)) && (s[7] != a[7]);
        return o;
    endfunction : alu

    function automatic logic mem_ok(input logic [7:0] a);
        return ({24'h000000, a} < MEM_DEPTH);
    endfunction : mem_ok

    // Word operand: even, within the word window, both bytes present
    function automatic logic word_ok(input logic [7:0] a);
        return (a <= `CDTP_WORD_ADDR_MAX) && !a[0] && mem_ok(a + 8'h01);
    endfunction : word_ok

    logic                  setup;
    logic                  access;
    logic                  take_cmd;
    cdtp_pkg::cdtp_op_e    op;
    logic [7:0]            oaddr;
    logic [7:0]            imm;
    logic [MEM_AW-1:0]     mi;
    logic [IO_AW-1:0]      ii;
    cdtp_pkg::cdtp_alu_s   ar;

    always_comb begin
        setup = psel && !penable;
        access = psel && penable && r_q.ready;
        take_cmd = access && pwrite && !r_q.slverr && (paddr == `CDTP_OFF_CMD);
        op = cdtp_pkg::cdtp_op_e'(pwdata[`CDTP_CMD_OP_LSB +: 4]);
        oaddr = pwdata[`CDTP_CMD_ADDR_LSB +: 8];
        imm = pwdata[`CDTP_CMD_IMM_LSB +: 8];
        mi = oaddr[MEM_AW-1:0];
        ii = oaddr[IO_AW-1:0];
        ar = alu(r_q.acc, imm, op == cdtp_pkg::CDTP_OP_SUBI);
    end

    always_comb begin
        r_d = r_q;
        r_d.ready = 1'b0;
        r_d.slverr = 1'b0;
        r_d.rdata = 32'h00000000;

        // Free running counter; a load below takes priority
        if (r_q.cnt_en) begin
            r_d.count = r_q.count + 16'h0001;
        end

        // Answer is prepared in the setup cycle, so pready and prdata come from flops
        if (setup) begin
            r_d.ready = 1'b1;
            unique case (paddr)
                `CDTP_OFF_CMD: begin
                    r_d.slverr = !pwrite || (r_q.st != cdtp_pkg::CDTP_ST_IDLE);
                end
                `CDTP_OFF_STATUS: begin
                    r_d.rdata[`CDTP_ST_Z] = r_q.flags.z;
                    r_d.rdata[`CDTP_ST_C] = r_q.flags.c;
                    r_d.rdata[`CDTP_ST_AC] = r_q.flags.half_nibble_flag;
                    r_d.rdata[`CDTP_ST_OV] = r_q.flags.signed_range_flag;
                    r_d.rdata[`CDTP_ST_ERR] = r_q.err;
                    r_d.rdata[`CDTP_ST_BUSY] = (r_q.st != cdtp_pkg::CDTP_ST_IDLE);
                end
                `CDTP_OFF_ACC: begin
                    r_d.rdata[7:0] = r_q.acc;
                    r_d.slverr = pwrite;
                end
                `CDTP_OFF_COUNT: begin
                    r_d.rdata[15:0] = r_q.count;
                    r_d.slverr = pwrite;
                end
                `CDTP_OFF_CTRL: begin
                    r_d.rdata[`CDTP_CTRL_CNT_EN] = r_q.cnt_en;
                end
                default: begin
                    r_d.slverr = 1'b1;
                end
            endcase
        end

        // Register writes other than commands
        if (access && pwrite && !r_q.slverr) begin
            if (paddr == `CDTP_OFF_STATUS && pwdata[`CDTP_ST_ERR]) begin
                r_d.err = 1'b0;
            end
            if (paddr == `CDTP_OFF_CTRL) begin
                r_d.cnt_en = pwdata[`CDTP_CTRL_CNT_EN];
            end
        end

        // Second cycle of the indirect read
        if (r_q.st == cdtp_pkg::CDTP_ST_IDX2) begin
            r_d.acc = r_q.mem[r_q.ptr[MEM_AW-1:0]];
            r_d.st = cdtp_pkg::CDTP_ST_IDLE;
        end

        // Commands execute at the edge that completes the write; a bad operand
        // leaves every state untouched and raises the sticky error
        if (take_cmd) begin
            unique case (op)
                cdtp_pkg::CDTP_OP_MOVI: begin
                    r_d.acc = imm;
                end
                cdtp_pkg::CDTP_OP_ACC2MEM: begin
                    if (mem_ok(oaddr)) begin
                        r_d.mem[mi] = r_q.acc;
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_MEM2ACC: begin
                    if (mem_ok(oaddr)) begin
                        r_d.acc = r_q.mem[mi];
                        r_d.flags.z = (r_q.mem[mi] == 8'h00);
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_IO2ACC: begin
                    if ({24'h000000, oaddr} < IO_DEPTH) begin
                        r_d.acc = r_q.io[ii];
                        r_d.flags.z = (r_q.io[ii] == 8'h00);
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_ACC2IO: begin
                    if ({24'h000000, oaddr} < IO_DEPTH) begin
                        r_d.io[ii] = r_q.acc;
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_CNT_RD: begin
                    if (word_ok(oaddr)) begin
                        r_d.mem[mi] = r_q.count[7:0];
                        r_d.mem[mi + 1'b1] = r_q.count[15:8];
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_CNT_WR: begin
                    if (word_ok(oaddr)) begin
                        r_d.count = {r_q.mem[mi + 1'b1], r_q.mem[mi]};
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_IDX_RD: begin
                    // Pointer high byte must be zero and the target must exist
                    if (word_ok(oaddr) && r_q.mem[mi + 1'b1] == 8'h00
                            && mem_ok(r_q.mem[mi])) begin
                        r_d.ptr = r_q.mem[mi];
                        r_d.st = cdtp_pkg::CDTP_ST_IDX2;
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                cdtp_pkg::CDTP_OP_ADDI, cdtp_pkg::CDTP_OP_SUBI: begin
                    r_d.acc = ar.res;
                    r_d.flags = ar.flags;
                end
                cdtp_pkg::CDTP_OP_SETB: begin
                    if (oaddr <= `CDTP_BIT_ADDR_MAX && mem_ok(oaddr)) begin
                        r_d.mem[mi][imm[2:0]] = imm[3];
                    end else begin
                        r_d.err = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q.st <= cdtp_pkg::CDTP_ST_IDLE;
            r_q.acc <= `CDTP_RST_ACC;
            r_q.flags <= '0;
            r_q.err <= 1'b0;
            r_q.cnt_en <= 1'b0;
            r_q.count <= `CDTP_RST_COUNT;
            r_q.ptr <= 8'h00;
            r_q.mem <= '0;
            r_q.io <= '0;
            r_q.rdata <= 32'h00000000;
            r_q.ready <= 1'b0;
            r_q.slverr <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    always_comb begin
        prdata = r_q.rdata;
        pready = r_q.ready;
        pslverr = r_q.slverr;
        io_port_lines = r_q.io[0];
    end

endmodule : cdtp_core
`default_nettype wire

// >>> cdtp_map.svh
// Register offsets, field positions, reset values and timing counts of the data path
`ifndef CDTP_MAP_SVH
`define CDTP_MAP_SVH

`define CDTP_OFF_CMD      12'h000
`define CDTP_OFF_STATUS   12'h004
`define CDTP_OFF_ACC      12'h008
`define CDTP_OFF_COUNT    12'h00c
`define CDTP_OFF_CTRL     12'h010

`define CDTP_CMD_OP_LSB   16
`define CDTP_CMD_ADDR_LSB 8
`define CDTP_CMD_IMM_LSB  0

`define CDTP_ST_Z         0
`define CDTP_ST_C         1
`define CDTP_ST_AC        2
`define CDTP_ST_OV        3
`define CDTP_ST_ERR       4
`define CDTP_ST_BUSY      5
`define CDTP_CTRL_CNT_EN  0

`define CDTP_RST_ACC      8'h00
`define CDTP_RST_COUNT    16'h0000

`define CDTP_WORD_ADDR_MAX 8'h1f
`define CDTP_BIT_ADDR_MAX  8'h0f
`define CDTP_IDX_CYCLES    2

`endif

// >>> cdtp_pkg.sv
// Types shared by the data transfer path
`default_nettype none
package cdtp_pkg;

    typedef enum logic [3:0] {
        CDTP_OP_NOP     = 4'h0,
        CDTP_OP_MOVI    = 4'h1,
        CDTP_OP_ACC2MEM = 4'h2,
        CDTP_OP_MEM2ACC = 4'h3,
        CDTP_OP_IO2ACC  = 4'h4,
        CDTP_OP_ACC2IO  = 4'h5,
        CDTP_OP_CNT_RD  = 4'h6,
        CDTP_OP_CNT_WR  = 4'h7,
        CDTP_OP_IDX_RD  = 4'h8,
        CDTP_OP_ADDI    = 4'h9,
        CDTP_OP_SUBI    = 4'ha,
        CDTP_OP_SETB    = 4'hb
    } cdtp_op_e;

    typedef enum logic [1:0] {
        CDTP_ST_IDLE = 2'b01,
        CDTP_ST_IDX2 = 2'b10
    } cdtp_state_e;

    typedef struct packed {
        logic signed_range_flag;
        logic half_nibble_flag;
        logic c;
        logic z;
    } cdtp_flags_s;

    typedef struct packed {
        logic [7:0]  res;
        cdtp_flags_s flags;
    } cdtp_alu_s;

endpackage : cdtp_pkg
`default_nettype wire

// >>> cdtp_core_assertions.sv
// Port checks of the data transfer path
`default_nettype none
module cdtp_core_assertions (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Port lines
    input wire logic [7:0]  io_port_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
    property p_idle_zero;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle data not zero");
    property p_ro_write_err;
        psel && !penable && pwrite && (paddr == 12'h008 || paddr == 12'h00c) |=> pslverr;
    endproperty
    a_ro_write_err: assert property (p_ro_write_err) else $error("read-only write taken");
    property p_cmd_read_err;
        psel && !penable && !pwrite && paddr == 12'h000 |=> pslverr;
    endproperty
    a_cmd_read_err: assert property (p_cmd_read_err) else $error("command read taken");
    property p_ctrl_ok;
        psel && !penable && paddr == 12'h010 |=> pready && !pslverr;
    endproperty
    a_ctrl_ok: assert property (p_ctrl_ok) else $error("control access refused");
    property p_io_cause;
        $changed(io_port_lines) |-> $past(psel && penable && pwrite && paddr == 12'h000
            && pwdata[19:16] == 4'h5 && pwdata[15:8] == 8'h00);
    endproperty
    a_io_cause: assert property (p_io_cause) else $error("port lines moved");
endmodule : cdtp_core_assertions
bind cdtp_core cdtp_core_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_port_lines(io_port_lines));
`default_nettype wire

// >>> cdtp_port_mon.sv
// Board listener on the IO port lines
`default_nettype none
module cdtp_port_mon (
    // Clock
    input wire logic       pclk,
    // Port lines and their latched level
    input wire logic [7:0] io_port_lines,
    output logic     [7:0] seen_q
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge pclk) begin
        seen_q <= io_port_lines;
    end
endmodule : cdtp_port_mon
`default_nettype wire

// >>> cdtp_core_tb.sv
// Self-checking bench of the data transfer path
`default_nettype none
module cdtp_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  io_port_lines;
    logic [7:0]  seen_q;
    logic [31:0] q;
    int          errors;
    int          num_checks;
    cdtp_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .io_port_lines(io_port_lines));
    cdtp_port_mon mon_u (.pclk(pclk), .io_port_lines(io_port_lines), .seen_q(seen_q));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // One transfer; request held until ready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            $display("unexpected at %0t: bus hang", $time);
            end_of_test();
        end
        q = prdata;
        chk({31'h0, pslverr}, {31'h0, e});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        chk(q, e);
    endtask : rd
    task mv(input logic [3:0] o, input logic [7:0] a, input logic [7:0] i);
        apb(1'b1, 12'h000, {12'h000, o, a, i}, 1'b0);
    endtask : mv
    task t_reset;
        rd(12'h004, 32'h0);
        rd(12'h00c, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 1'b1);
        apb(1'b1, 12'h008, 32'h1, 1'b1);
        apb(1'b0, 12'h000, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h0, 1'b0);
        rd(12'h010, 32'h0);
    endtask : t_reset
    task t_alu;
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h7f);
        mv(cdtp_pkg::CDTP_OP_ADDI, 8'h00, 8'h01);
        rd(12'h004, 32'h0c);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h00);
        rd(12'h004, 32'h0c);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h01);
        mv(cdtp_pkg::CDTP_OP_ADDI, 8'h00, 8'hff);
        rd(12'h004, 32'h07);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h80);
        mv(cdtp_pkg::CDTP_OP_SUBI, 8'h00, 8'h01);
        rd(12'h004, 32'h0c);
        rd(12'h008, 32'h7f);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h70);
        mv(cdtp_pkg::CDTP_OP_SUBI, 8'h00, 8'h81);
        rd(12'h004, 32'h0e);
        rd(12'h008, 32'hef);
    endtask : t_alu
    task t_moves;
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h00);
        mv(cdtp_pkg::CDTP_OP_ACC2MEM, 8'h03, 8'h00);
        rd(12'h004, 32'h0e);
        mv(cdtp_pkg::CDTP_OP_MEM2ACC, 8'h03, 8'h00);
        rd(12'h004, 32'h0f);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h5a);
        mv(cdtp_pkg::CDTP_OP_ACC2IO, 8'h00, 8'h00);
        rd(12'h004, 32'h0f);
        chk({24'h0, seen_q}, 32'h5a);
        mv(cdtp_pkg::CDTP_OP_IO2ACC, 8'h00, 8'h00);
        rd(12'h004, 32'h0e);
        rd(12'h008, 32'h5a);
    endtask : t_moves
    task t_counter;
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h34);
        mv(cdtp_pkg::CDTP_OP_ACC2MEM, 8'h04, 8'h00);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h12);
        mv(cdtp_pkg::CDTP_OP_ACC2MEM, 8'h05, 8'h00);
        mv(cdtp_pkg::CDTP_OP_CNT_WR, 8'h04, 8'h00);
        rd(12'h00c, 32'h1234);
        mv(cdtp_pkg::CDTP_OP_CNT_RD, 8'h06, 8'h00);
        mv(cdtp_pkg::CDTP_OP_MEM2ACC, 8'h06, 8'h00);
        rd(12'h008, 32'h34);
        mv(cdtp_pkg::CDTP_OP_MEM2ACC, 8'h07, 8'h00);
        rd(12'h008, 32'h12);
        mv(cdtp_pkg::CDTP_OP_CNT_WR, 8'h20, 8'h00);
        rd(12'h004, 32'h1e);
        rd(12'h00c, 32'h1234);
        apb(1'b1, 12'h004, 32'h10, 1'b0);
        rd(12'h004, 32'h0e);
        // Counter runs from the enabling write edge to the disabling one: three edges
        apb(1'b1, 12'h010, 32'h1, 1'b0);
        apb(1'b1, 12'h010, 32'h0, 1'b0);
        rd(12'h00c, 32'h1237);
    endtask : t_counter
    task t_index;
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'ha5);
        mv(cdtp_pkg::CDTP_OP_ACC2MEM, 8'h0a, 8'h00);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h0a);
        mv(cdtp_pkg::CDTP_OP_ACC2MEM, 8'h08, 8'h00);
        mv(cdtp_pkg::CDTP_OP_MOVI, 8'h00, 8'h00);
        mv(cdtp_pkg::CDTP_OP_ACC2MEM, 8'h09, 8'h00);
        mv(cdtp_pkg::CDTP_OP_IDX_RD, 8'h08, 8'h00);
        rd(12'h008, 32'ha5);
        rd(12'h004, 32'h0e);
        mv(cdtp_pkg::CDTP_OP_SETB, 8'h10, 8'h0b);
        rd(12'h004, 32'h1e);
        apb(1'b1, 12'h004, 32'h10, 1'b0);
        mv(cdtp_pkg::CDTP_OP_SETB, 8'h02, 8'h0b);
        mv(cdtp_pkg::CDTP_OP_MEM2ACC, 8'h02, 8'h00);
        rd(12'h008, 32'h08);
    endtask : t_index
    initial begin
        errors     = 0;
        num_checks = 0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_alu();
        t_moves();
        t_counter();
        t_index();
        end_of_test();
    end
endmodule : cdtp_core_tb
`default_nettype wire
